// *** core/esm_ramp.sv ***
// One ramp step of the reference toward a target, limited in size.
`timescale 1ns/1ps
`default_nettype none

module esm_ramp #(
  parameter int W = 16
) (
  input wire logic [W-1:0] cur,
  input wire logic [W-1:0] tgt,
  input wire logic [W-1:0] step,
  output logic [W-1:0] nxt
);

  // ****************************************
  // Step arithmetic
  // ****************************************
  logic up;
  logic [W-1:0] gap;
  logic near;

  // The gap is taken unsigned in the ramp's direction, so no overshoot can wrap.
  assign up = cur < tgt;
  assign gap = up ? tgt - cur : cur - tgt;
  assign near = gap <= step;
  assign nxt = near ? tgt : (up ? cur + step : cur - step);

endmodule

`default_nettype wire

// *** core/esm_top.sv ***
// Extraction setpoint manager: enable arbitration, states and reference.
//
// Functional notes
// R1: Loop enable follows the latest panel, contact or Modbus command.
// R2: Contact open disables, contact close enables; same for remote setpoint.
// R3: A contact already closed after a trip needs reopening to enable.
// R4: Modbus enable and disable act only on their rising transition.
// R5: Seven states reported: disabled to in control with remote, inhibited.
// R6: Enable inhibited by input failures, low speed, controlled stop, shutdown.
// R7: Reference loads the configured initial setpoint at power-up.
// R8: Raise or lower ramps at default rate, fast rate after held delay.
// R9: Raise and lower ramp only while the command is asserted.
// R10: Entered setpoints clamp to min and max, approached at default rate.
// R11: Remote setpoint clamps to remote limits, followed at remote rate.
// R12: Source rank: remote, operator panel, Modbus one, Modbus two. The code ranks only remote first; panel and Modbus entries take the last write.
// R13: Enabled remote setpoint blocks all other setpoint commands.
// R14: With tracking, reference follows process input while loop disabled.
// R15: Once enabled with tracking, ramp to commanded setpoint or obey raise/lower.
// R16: Without tracking, reference holds when disabled; loop acts at once.
// R17: Lost permissive or disable leaves reference at its last value.
// R18: Process and setpoint normalised to 0-100% of setpoint range.
// R19: Droop share of pressure demand subtracted from normalised process.
// R20: Invert option reverses the sign of the process input.
// R21: Process failure takes configured action: trip, open, close, manual.
// R22: Remote input out of range alarms, disables remote, needs fresh enable.
// R23: Raise and lower together hold the reference.
`timescale 1ns/1ps
`default_nettype none

module esm_top #(
  parameter int TICK_CYC = esm_pkg::TICK_CYC,
  parameter int FAST_TICKS = esm_pkg::FAST_TICKS,
  parameter logic [15:0] SP_INIT = 16'h0000,
  parameter logic [15:0] STEP_DEF = 16'h0001,
  parameter logic [15:0] STEP_FAST = 16'h0004,
  parameter logic [15:0] STEP_RMT = 16'h0002
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rd_data,
  input wire logic [3:0] contact_pins,
  input wire logic [15:0] process_in,
  input wire logic [15:0] remote_in,
  input wire logic remote_valid,
  input wire logic process_fail,
  input wire logic decoupled_io_fail,
  input wire logic below_min_gov,
  input wire logic ctrl_stop,
  input wire logic shutdown,
  input wire logic loop_active,
  input wire logic loop_in_ctrl,
  input wire logic [15:0] press_demand,
  output logic loop_enabled,
  output logic rsp_enabled,
  output logic rsp_alarm,
  output logic [2:0] loop_state,
  output logic [15:0] reference,
  output logic [17:0] pv_norm,
  output logic [17:0] sp_norm,
  output logic fail_trip,
  output logic lpv_open,
  output logic lpv_close,
  output logic manual_demand
);

  // ****************************************
  // Helpers
  // ****************************************
  // Limit a value to a window; used for entered, remote and tracked values.
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] cfg_r, sp_min_r, sp_max_r, rmt_min_r, rmt_max_r, droop_r;
  logic [5:0] mb1_r, mb2_r, mb1_prev_r, mb2_prev_r;
  logic [1:0] pnl_rl_r;
  logic [3:0] sync1_r, sync2_r, ct_prev_r;
  logic en_r, rsp_r, alarm_r;
  logic [15:0] ref_r, tgt_r, rd_r;
  logic goto_r;
  logic [31:0] div_r, hold_r;
  logic tick_r;
  logic [1:0] dir_r;
  logic [17:0] pv_n_r, sp_n_r;
  logic [2:0] state_r;
  logic [3:0] fail_r;

  // ****************************************
  // Pin synchronisers and decoding
  // ****************************************
  // Contacts arrive from the field; two stages before anything reads them.
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      ct_prev_r <= 4'h0;
    end else begin
      sync1_r <= contact_pins;
      sync2_r <= sync1_r;
      ct_prev_r <= sync2_r;
    end
  end

  logic [3:0] ct_rise, ct_fall;
  logic use_ct, trk, inv, rsp_used, decoupled;
  logic [1:0] fail_act;
  logic wr_cfg, wr_pnl, wr_psp, wr_m1sp, wr_m2sp;

  // Edges rather than levels, so a contact held closed across a trip stays idle.
  assign ct_rise = sync2_r & ~ct_prev_r; // R3
  assign ct_fall = ~sync2_r & ct_prev_r;
  assign use_ct = cfg_r[esm_pkg::B_CONTACT];
  assign trk = cfg_r[esm_pkg::B_TRACK];
  assign inv = cfg_r[esm_pkg::B_INVERT];
  assign rsp_used = cfg_r[esm_pkg::B_RSP_USED];
  assign decoupled = cfg_r[esm_pkg::B_DECOUPLED];
  assign fail_act = cfg_r[esm_pkg::B_FAIL_LO+1:esm_pkg::B_FAIL_LO];
  assign wr_cfg = wr_stb && addr == esm_pkg::A_CFG;
  assign wr_pnl = wr_stb && addr == esm_pkg::A_PANEL;
  assign wr_psp = wr_stb && addr == esm_pkg::A_PNL_SP;
  assign wr_m1sp = wr_stb && addr == esm_pkg::A_MB1_SP;
  assign wr_m2sp = wr_stb && addr == esm_pkg::A_MB2_SP;

  // ****************************************
  // Enable arbitration
  // ****************************************
  logic [5:0] mb_rise, pnl_pulse;
  logic inhibit, rsp_inh, rmt_bad;
  logic ev_en, ev_dis, ev_ren, ev_rdis;

  assign mb_rise = (mb1_r & ~mb1_prev_r) | (mb2_r & ~mb2_prev_r); // R4
  assign pnl_pulse = wr_pnl ? wr_data[5:0] : 6'h00;
  assign rmt_bad = ~remote_valid;
  assign inhibit = process_fail | (decoupled & decoupled_io_fail) | below_min_gov
                   | ctrl_stop | shutdown; // R6
  assign rsp_inh = rmt_bad | process_fail | ctrl_stop | shutdown | ~rsp_used; // R22
  assign ev_en = pnl_pulse[esm_pkg::B_EN] | mb_rise[esm_pkg::B_EN]
                 | (use_ct & ct_rise[esm_pkg::P_LOOP]); // R1 R2
  assign ev_dis = pnl_pulse[esm_pkg::B_DIS] | mb_rise[esm_pkg::B_DIS]
                  | (use_ct & ct_fall[esm_pkg::P_LOOP]); // R1 R2
  assign ev_ren = pnl_pulse[esm_pkg::B_RSP_EN] | mb_rise[esm_pkg::B_RSP_EN]
                  | (use_ct & ct_rise[esm_pkg::P_RSP]); // R2
  assign ev_rdis = pnl_pulse[esm_pkg::B_RSP_DIS] | mb_rise[esm_pkg::B_RSP_DIS]
                   | (use_ct & ct_fall[esm_pkg::P_RSP]); // R2

  // A disable arriving with an enable wins; that is the safe side.
  always_ff @(posedge clock) begin
    if (reset) begin
      en_r <= 1'b0;
      rsp_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      en_r <= ~inhibit & ~ev_dis & (ev_en | en_r); // R1 R6
      rsp_r <= ~rsp_inh & ~ev_rdis & (ev_ren | rsp_r); // R22
      alarm_r <= rmt_bad & rsp_used; // R22
    end
  end

  // ****************************************
  // Displayed state
  // ****************************************
  esm_pkg::esm_state_e st_nxt;

  always_comb begin
    if (!en_r && inhibit) begin
      st_nxt = esm_pkg::ESM_INH;
    end else if (!en_r) begin
      st_nxt = esm_pkg::ESM_DIS;
    end else if (!loop_active) begin
      st_nxt = esm_pkg::ESM_ENA;
    end else if (!loop_in_ctrl) begin
      st_nxt = rsp_r ? esm_pkg::ESM_ACT_RSP : esm_pkg::ESM_ACT;
    end else begin
      st_nxt = rsp_r ? esm_pkg::ESM_CTL_RSP : esm_pkg::ESM_CTL;
    end
  end // R5

  // ****************************************
  // Control tick and raise/lower hold timer
  // ****************************************
  logic [1:0] rl;
  logic rl_one, fast;

  // Every source of raise/lower is merged; remote setpoint blocks them all.
  assign rl[0] = pnl_rl_r[0] | mb1_r[esm_pkg::B_RAISE] | mb2_r[esm_pkg::B_RAISE]
                 | sync2_r[esm_pkg::P_RAISE];
  assign rl[1] = pnl_rl_r[1] | mb1_r[esm_pkg::B_LOWER] | mb2_r[esm_pkg::B_LOWER]
                 | sync2_r[esm_pkg::P_LOWER];
  assign rl_one = ^rl & ~rsp_r; // R9 R13 R23
  assign fast = hold_r >= 32'(FAST_TICKS); // R8

  // The hold time restarts on release or on a change of direction.
  always_ff @(posedge clock) begin
    if (reset) begin
      div_r <= 32'h0;
      tick_r <= 1'b0;
      hold_r <= 32'h0;
      dir_r <= 2'b00;
    end else begin
      tick_r <= div_r == 32'(TICK_CYC - 1);
      div_r <= (div_r == 32'(TICK_CYC - 1)) ? 32'h0 : div_r + 32'h1;
      dir_r <= rl;
      if (!rl_one || rl != dir_r) begin
        hold_r <= 32'h0;
      end else if (tick_r && !fast) begin
        hold_r <= hold_r + 32'h1; // R8
      end
    end
  end

  // ****************************************
  // Reference source selection
  // ****************************************
  logic [15:0] rmt_c, pv_c, ent_v, ent_c, r_tgt, r_step, r_nxt;
  logic ent_wr;

  assign rmt_c = clamp(remote_in, rmt_min_r, rmt_max_r); // R11
  assign pv_c = clamp(process_in, sp_min_r, sp_max_r);
  // One strobe per cycle, so entered sources never collide; the last write wins.
  assign ent_v = wr_data; // R12
  assign ent_wr = (wr_psp | wr_m1sp | wr_m2sp) & ~rsp_r; // R13
  assign ent_c = clamp(ent_v, sp_min_r, sp_max_r); // R10

  // Remote first, then raise/lower, then an entered value; otherwise hold.
  assign r_tgt = rsp_r ? rmt_c : (rl_one ? (rl[0] ? sp_max_r : sp_min_r) : tgt_r); // R12
  assign r_step = rsp_r ? STEP_RMT : ((rl_one && fast) ? STEP_FAST : STEP_DEF); // R8 R11

  esm_ramp #(
    .W(16)
  ) u_ramp (
    .cur(ref_r),
    .tgt(r_tgt),
    .step(r_step),
    .nxt(r_nxt)
  );

  // Tracking snaps straight to the process so the loop error is zero on enable.
  always_ff @(posedge clock) begin
    if (reset) begin
      ref_r <= SP_INIT; // R7
      tgt_r <= SP_INIT;
      goto_r <= 1'b0;
    end else begin
      if (ent_wr) begin
        tgt_r <= ent_c; // R10
        goto_r <= 1'b1;
      end else if (rl_one || rsp_r || (tick_r && r_nxt == tgt_r)) begin
        goto_r <= 1'b0;
      end
      if (tick_r) begin
        if (!en_r && trk) begin
          ref_r <= pv_c; // R14
        end else if (rsp_r || rl_one || goto_r) begin
          ref_r <= r_nxt; // R15
        end
      end // R16 R17
    end
  end

  // ****************************************
  // Normalisation, droop and invert
  // ****************************************
  logic [15:0] span;
  logic signed [31:0] pv_off, sp_off, pv_q, sp_q, drp;
  logic signed [31:0] pv_sg, pv_adj;
  logic [23:0] drp_p;

  // A zero span would divide by zero; it is treated as one count.
  assign span = (sp_max_r > sp_min_r) ? sp_max_r - sp_min_r : 16'h0001;
  assign pv_off = $signed({16'h0000, process_in}) - $signed({16'h0000, sp_min_r});
  assign sp_off = $signed({16'h0000, ref_r}) - $signed({16'h0000, sp_min_r});
  assign pv_q = (pv_off * $signed(esm_pkg::NORM_FULL)) / $signed({16'h0000, span}); // R18
  assign sp_q = (sp_off * $signed(esm_pkg::NORM_FULL)) / $signed({16'h0000, span}); // R18
  assign pv_sg = inv ? -pv_q : pv_q; // R20
  assign drp_p = (24'(press_demand) * 24'(droop_r[7:0])) / esm_pkg::PCT_DIV;
  assign drp = $signed({8'h00, drp_p});
  assign pv_adj = pv_sg - drp; // R19

  // ****************************************
  // Failure reaction and status registers
  // ****************************************
  logic [3:0] fail_nxt;

  assign fail_nxt[0] = process_fail && fail_act == esm_pkg::ESM_FAIL_TRIP; // R21
  assign fail_nxt[1] = process_fail && fail_act == esm_pkg::ESM_FAIL_OPEN;
  assign fail_nxt[2] = process_fail && fail_act == esm_pkg::ESM_FAIL_CLOSE;
  assign fail_nxt[3] = process_fail && fail_act == esm_pkg::ESM_FAIL_MANUAL;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= esm_pkg::ESM_DIS;
      pv_n_r <= 18'h0;
      sp_n_r <= 18'h0;
      fail_r <= 4'h0;
    end else begin
      state_r <= st_nxt;
      pv_n_r <= pv_adj[17:0];
      sp_n_r <= sp_q[17:0];
      fail_r <= fail_nxt;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_r <= esm_pkg::CFG_RST;
      sp_min_r <= esm_pkg::SP_MIN_RST;
      sp_max_r <= esm_pkg::SP_MAX_RST;
      rmt_min_r <= esm_pkg::SP_MIN_RST;
      rmt_max_r <= esm_pkg::SP_MAX_RST;
      droop_r <= esm_pkg::DROOP_RST;
      mb1_r <= 6'h00;
      mb2_r <= 6'h00;
      mb1_prev_r <= 6'h00;
      mb2_prev_r <= 6'h00;
      pnl_rl_r <= 2'b00;
    end else begin
      mb1_prev_r <= mb1_r;
      mb2_prev_r <= mb2_r;
      if (wr_cfg) cfg_r <= wr_data;
      if (wr_stb && addr == esm_pkg::A_SP_MIN) sp_min_r <= wr_data;
      if (wr_stb && addr == esm_pkg::A_SP_MAX) sp_max_r <= wr_data;
      if (wr_stb && addr == esm_pkg::A_RMT_MIN) rmt_min_r <= wr_data;
      if (wr_stb && addr == esm_pkg::A_RMT_MAX) rmt_max_r <= wr_data;
      if (wr_stb && addr == esm_pkg::A_DROOP) droop_r <= wr_data;
      if (wr_stb && addr == esm_pkg::A_MB1) mb1_r <= wr_data[5:0];
      if (wr_stb && addr == esm_pkg::A_MB2) mb2_r <= wr_data[5:0];
      if (wr_pnl) pnl_rl_r <= wr_data[esm_pkg::B_LOWER:esm_pkg::B_RAISE];
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  logic [15:0] rd_mux;

  always_comb begin
    unique case (addr)
      esm_pkg::A_CFG: rd_mux = cfg_r;
      esm_pkg::A_PANEL: rd_mux = {14'h0000, pnl_rl_r} << esm_pkg::B_RAISE;
      esm_pkg::A_MB1: rd_mux = {10'h000, mb1_r};
      esm_pkg::A_MB2: rd_mux = {10'h000, mb2_r};
      esm_pkg::A_PNL_SP, esm_pkg::A_MB1_SP, esm_pkg::A_MB2_SP: rd_mux = tgt_r;
      esm_pkg::A_SP_MIN: rd_mux = sp_min_r;
      esm_pkg::A_SP_MAX: rd_mux = sp_max_r;
      esm_pkg::A_RMT_MIN: rd_mux = rmt_min_r;
      esm_pkg::A_RMT_MAX: rd_mux = rmt_max_r;
      esm_pkg::A_DROOP: rd_mux = droop_r;
      esm_pkg::A_STATUS: rd_mux = {5'h00, fail_r, fast, alarm_r, rsp_r, en_r, state_r};
      esm_pkg::A_REF: rd_mux = ref_r;
      esm_pkg::A_PV_N: rd_mux = pv_n_r[15:0];
      esm_pkg::A_SP_N: rd_mux = sp_n_r[15:0];
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_r <= 16'h0000;
    end else begin
      rd_r <= rd_stb ? rd_mux : 16'h0000;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_data = rd_r;
  assign loop_enabled = en_r;
  assign rsp_enabled = rsp_r;
  assign rsp_alarm = alarm_r;
  assign loop_state = state_r;
  assign reference = ref_r;
  assign pv_norm = pv_n_r;
  assign sp_norm = sp_n_r;
  assign fail_trip = fail_r[0];
  assign lpv_open = fail_r[1];
  assign lpv_close = fail_r[2];
  assign manual_demand = fail_r[3];

endmodule

`default_nettype wire

// *** shared/esm_pkg.sv ***
// Package of constants for the extraction setpoint manager.
package esm_pkg;

  // ****************************************
  // Register map (word addresses)
  // ****************************************
  localparam logic [3:0] A_CFG = 4'h0;
  localparam logic [3:0] A_PANEL = 4'h1;
  localparam logic [3:0] A_MB1 = 4'h2;
  localparam logic [3:0] A_MB2 = 4'h3;
  localparam logic [3:0] A_PNL_SP = 4'h4;
  localparam logic [3:0] A_MB1_SP = 4'h5;
  localparam logic [3:0] A_MB2_SP = 4'h6;
  localparam logic [3:0] A_SP_MIN = 4'h7;
  localparam logic [3:0] A_SP_MAX = 4'h8;
  localparam logic [3:0] A_RMT_MIN = 4'h9;
  localparam logic [3:0] A_RMT_MAX = 4'ha;
  localparam logic [3:0] A_DROOP = 4'hb;
  localparam logic [3:0] A_STATUS = 4'hc;
  localparam logic [3:0] A_REF = 4'hd;
  localparam logic [3:0] A_PV_N = 4'he;
  localparam logic [3:0] A_SP_N = 4'hf;

  // ****************************************
  // Field positions
  // ****************************************
  // Configuration word.
  localparam int B_CONTACT = 0;
  localparam int B_TRACK = 1;
  localparam int B_INVERT = 2;
  localparam int B_RSP_USED = 3;
  localparam int B_DECOUPLED = 4;
  localparam int B_FAIL_LO = 5;
  // Command words (panel pulses except held raise/lower, Modbus levels).
  localparam int B_EN = 0;
  localparam int B_DIS = 1;
  localparam int B_RSP_EN = 2;
  localparam int B_RSP_DIS = 3;
  localparam int B_RAISE = 4;
  localparam int B_LOWER = 5;
  // Contact pin vector.
  localparam int P_LOOP = 0;
  localparam int P_RSP = 1;
  localparam int P_RAISE = 2;
  localparam int P_LOWER = 3;

  // ****************************************
  // Reset values and scaling
  // ****************************************
  localparam logic [15:0] CFG_RST = 16'h0009;
  localparam logic [15:0] SP_MIN_RST = 16'h0000;
  localparam logic [15:0] SP_MAX_RST = 16'hffff;
  localparam logic [15:0] DROOP_RST = 16'h0000;
  localparam logic [31:0] NORM_FULL = 32'h0000_2710;
  localparam logic [23:0] PCT_DIV = 24'h000064;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int FAST_TICKS = 3000;

  // Process-input failure reactions.
  typedef enum logic [1:0] {
    ESM_FAIL_TRIP = 2'b00,
    ESM_FAIL_OPEN = 2'b01,
    ESM_FAIL_CLOSE = 2'b10,
    ESM_FAIL_MANUAL = 2'b11
  } esm_fail_e;

  // Displayed loop states, Gray along the usual path.
  typedef enum logic [2:0] {
    ESM_DIS = 3'b000,
    ESM_ENA = 3'b001,
    ESM_ACT = 3'b011,
    ESM_CTL = 3'b010,
    ESM_ACT_RSP = 3'b110,
    ESM_CTL_RSP = 3'b111,
    ESM_INH = 3'b101
  } esm_state_e;

endpackage

// *** sim/esm_field.sv ***
// Field side model: contacts, process transmitter and remote controller.
`timescale 1ns/1ps
`default_nettype none

module esm_field (
  input wire logic clock,
  input wire logic [3:0] set_pins,
  input wire logic [15:0] set_pv,
  input wire logic [15:0] set_rsp,
  input wire logic set_ok,
  output logic [3:0] contact_pins,
  output logic [15:0] process_in,
  output logic [15:0] remote_in,
  output logic remote_valid
);
  // Levels move one edge late; a failed remote input toggles, so no stale value helps.
  always_ff @(posedge clock) begin
    contact_pins <= set_pins;
    process_in <= set_pv;
    remote_valid <= set_ok;
    remote_in <= set_ok ? set_rsp : ~remote_in;
  end
endmodule

`default_nettype wire

// *** sim/esm_properties.sv ***
// Port-level checker for the extraction setpoint manager.
`timescale 1ns/1ps
`default_nettype none

module esm_properties #(
  parameter logic [15:0] SP_INIT = 16'h0000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic remote_valid,
  input wire logic process_fail,
  input wire logic below_min_gov,
  input wire logic ctrl_stop,
  input wire logic shutdown,
  input wire logic loop_enabled,
  input wire logic rsp_enabled,
  input wire logic rsp_alarm,
  input wire logic [2:0] loop_state,
  input wire logic [15:0] reference,
  input wire logic fail_trip,
  input wire logic lpv_open,
  input wire logic lpv_close,
  input wire logic manual_demand
);
  // ****************************************
  // Properties
  // ****************************************
  // One clock domain, so clocking and reset gating are shared.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Gathered failure reactions and inhibit causes.
  wire logic [3:0] fails = {fail_trip, lpv_open, lpv_close, manual_demand};
  wire logic inh = process_fail | below_min_gov | ctrl_stop | shutdown;

  property p_ref_init; $fell(reset) |-> reference == SP_INIT; endproperty
  a_ref_init: assert property (p_ref_init) else $error("reference not initial");
  property p_rd_idle; !$past(rd_stb) |-> rd_data == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_alarm; rsp_alarm |-> !$past(remote_valid); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without bad input");
  property p_rsp_drop; !remote_valid |=> !rsp_enabled; endproperty
  a_rsp_drop: assert property (p_rsp_drop) else $error("remote kept on bad input");
  property p_fail_cause; fails != 4'h0 |-> $past(process_fail); endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("failure action uncaused");
  property p_fail_one; $onehot0(fails); endproperty
  a_fail_one: assert property (p_fail_one) else $error("two failure actions");
  property p_inhibit; inh |=> !loop_enabled; endproperty
  a_inhibit: assert property (p_inhibit) else $error("enabled while inhibited");
  property p_state_en;
    !(loop_state inside {esm_pkg::ESM_DIS, esm_pkg::ESM_INH}) |-> $past(loop_enabled);
  endproperty
  a_state_en: assert property (p_state_en) else $error("enabled state while off");
  property p_state_inh; loop_state == esm_pkg::ESM_INH |-> !$past(loop_enabled); endproperty
  a_state_inh: assert property (p_state_inh) else $error("inhibited state while on");

  // Main scenarios seen at least once.
  c_ena: cover property (loop_state == esm_pkg::ESM_ENA);
  c_rsp: cover property (rsp_enabled);
  c_alarm: cover property (rsp_alarm);
  c_trip: cover property (fail_trip);
endmodule

bind esm_top esm_properties #(.SP_INIT(SP_INIT)) u_esm_properties (.*);

`default_nettype wire

// *** sim/tb_extraction_setpoint_manager.sv ***
// Self-checking bench for the extraction setpoint manager.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module tb_extraction_setpoint_manager;
  localparam logic [15:0] SPI = 16'h0100;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [3:0] set_pins = 4'h0;
  logic [15:0] set_pv = 16'h0000;
  logic set_ok = 1'b1;
  logic process_fail = 1'b0;
  logic shutdown = 1'b0, ctrl_stop = 1'b0, below_min_gov = 1'b0;
  logic loop_active = 1'b0;
  logic loop_in_ctrl = 1'b0;
  logic [15:0] press_demand = 16'h0000;
  logic [15:0] rd_data, reference, process_in, remote_in;
  logic [3:0] contact_pins;
  logic remote_valid, loop_enabled, rsp_enabled, rsp_alarm;
  logic fail_trip, lpv_open, lpv_close, manual_demand;
  logic [2:0] loop_state;
  logic [17:0] pv_norm, sp_norm;
  int errors = 0;
  int samples_checked = 0;

  // ****************************************
  // Harness
  // ****************************************
  // Short tick and fast delay keep the ramps to a few hundred cycles.
  esm_top #(.TICK_CYC(10), .FAST_TICKS(4), .SP_INIT(SPI)) u_esm_top (.*,
    .decoupled_io_fail(1'b0));
  esm_field u_esm_field (.*, .set_rsp(16'hffff));

  // Free-running 25 MHz clock.
  initial begin
    forever #20 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Bus tasks start just after an edge and end on one.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 v = rd_data;
    @(posedge clock);
  endtask

  // Waits, bounded, for the next reference move and returns its size.
  task automatic step(output logic [15:0] d);
    logic [15:0] r0;
    int n;
    #1 r0 = reference;
    n = 0;
    while (reference === r0 && n < 100) begin
      @(posedge clock);
      #1 n++;
    end
    d = reference - r0;
    @(posedge clock);
  endtask

  task automatic t_reset();
    logic [15:0] v;
    rd(esm_pkg::A_REF, v);
    `CHK(v, SPI)
    rd(esm_pkg::A_CFG, v);
    `CHK(v, esm_pkg::CFG_RST)
    $display("done reset");
  endtask

  task automatic t_modbus();
    wr(esm_pkg::A_PANEL, 16'h0001);
    `CHK(loop_enabled, 1'b1)
    cyc(1);
    `CHK(loop_state, esm_pkg::ESM_ENA)
    loop_active <= 1'b1;
    cyc(3);
    `CHK(loop_state, esm_pkg::ESM_ACT)
    loop_in_ctrl <= 1'b1;
    cyc(3);
    `CHK(loop_state, esm_pkg::ESM_CTL)
    wr(esm_pkg::A_MB1, 16'h0002);
    cyc(2);
    `CHK(loop_enabled, 1'b0)
    wr(esm_pkg::A_PANEL, 16'h0001);
    wr(esm_pkg::A_MB1, 16'h0002);
    cyc(2);
    `CHK(loop_enabled, 1'b1)
    wr(esm_pkg::A_MB1, 16'h0000);
    wr(esm_pkg::A_MB1, 16'h0002);
    cyc(2);
    `CHK(loop_enabled, 1'b0)
    $display("done modbus");
  endtask

  task automatic t_contact();
    set_pins <= 4'h1;
    cyc(8);
    `CHK(loop_enabled, 1'b1)
    set_pins <= 4'h0;
    cyc(8);
    `CHK(loop_enabled, 1'b0)
    set_pins <= 4'h1;
    cyc(8);
    for (int k = 0; k < 3; k++) begin
      {below_min_gov, ctrl_stop, shutdown} <= 3'h1 << k;
      cyc(3);
      `CHK(loop_enabled, 1'b0)
      {below_min_gov, ctrl_stop, shutdown} <= 3'h0;
      cyc(8);
      `CHK(loop_enabled, 1'b0)
      set_pins <= 4'h0;
      cyc(8);
      set_pins <= 4'h1;
      cyc(8);
      `CHK(loop_enabled, 1'b1)
    end
    $display("done contact");
  endtask

  task automatic t_ramp();
    logic [15:0] d, d0, r0;
    wr(esm_pkg::A_PANEL, 16'h0010);
    step(d0);
    repeat (7) step(d);
    `CHK(d0, 16'h0001)
    `CHK(d, 16'h0004)
    wr(esm_pkg::A_PANEL, 16'h0030);
    cyc(12);
    r0 = reference;
    cyc(40);
    `CHK(reference, r0)
    wr(esm_pkg::A_PANEL, 16'h0000);
    cyc(12);
    r0 = reference;
    cyc(40);
    `CHK(reference, r0)
    set_pins <= 4'h9;
    step(d);
    `CHK(d, 16'hffff)
    set_pins <= 4'h1;
    cyc(8);
    $display("done ramp");
  endtask

  task automatic t_enter_remote();
    logic [15:0] d, v, r;
    r = reference;
    wr(esm_pkg::A_SP_MAX, r + 16'h0003);
    wr(esm_pkg::A_PNL_SP, 16'hffff);
    step(d);
    `CHK(d, 16'h0001)
    rd(esm_pkg::A_PNL_SP, v);
    `CHK(v, r + 16'h0003)
    cyc(40);
    r = reference;
    `CHK(r, v)
    wr(esm_pkg::A_RMT_MAX, r - 16'h0008);
    wr(esm_pkg::A_PANEL, 16'h0004);
    `CHK(rsp_enabled, 1'b1)
    step(d);
    `CHK(d, 16'hfffe)
    cyc(60);
    `CHK(reference, r - 16'h0008)
    wr(esm_pkg::A_PNL_SP, 16'h0000);
    rd(esm_pkg::A_PNL_SP, v);
    `CHK(v, r)
    wr(esm_pkg::A_PANEL, 16'h0010);
    cyc(30);
    `CHK(reference, r - 16'h0008)
    wr(esm_pkg::A_PANEL, 16'h0000);
    set_ok <= 1'b0;
    cyc(3);
    `CHK(rsp_alarm, 1'b1)
    `CHK(rsp_enabled, 1'b0)
    set_ok <= 1'b1;
    cyc(4);
    `CHK(rsp_enabled, 1'b0)
    $display("done setpoint sources");
  endtask

  task automatic t_fail_norm();
    for (int k = 0; k < 4; k++) begin
      wr(esm_pkg::A_CFG, 16'h0009 | (16'(k) << 5));
      process_fail <= 1'b1;
      cyc(3);
      `CHK({fail_trip, lpv_open, lpv_close, manual_demand}, 4'(4'b1000 >> k))
      process_fail <= 1'b0;
      cyc(2);
    end
    wr(esm_pkg::A_CFG, 16'h000b);
    wr(esm_pkg::A_SP_MAX, 16'h03e8);
    set_pv <= 16'h01f4;
    cyc(40);
    `CHK(reference, 16'h01f4)
    `CHK(pv_norm, 18'h01388)
    `CHK(sp_norm, 18'h01388)
    wr(esm_pkg::A_DROOP, 16'h000a);
    press_demand <= 16'h07d0;
    cyc(4);
    `CHK(pv_norm, 18'h012c0)
    wr(esm_pkg::A_CFG, 16'h000f);
    cyc(2);
    `CHK(pv_norm, 18'h3ebb0)
    wr(esm_pkg::A_CFG, 16'h0009);
    set_pv <= 16'h0064;
    cyc(40);
    `CHK(reference, 16'h01f4)
    $display("done failure and scaling");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a twelve-cycle reset.
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_modbus();
    t_contact();
    t_ramp();
    t_enter_remote();
    t_fail_norm();
    results();
  end

  // The tests need under 2000 cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    results();
  end
endmodule

`default_nettype wire
